// >>> hdl/cmod_defs.vh
// constants for the cache maintenance command decoder
// assumes inclusion by bare name from the design files
`ifndef CMOD_DEFS_VH
`define CMOD_DEFS_VH
// secondary codes
`define CMOD_SC_WFI 4'h0
`define CMOD_SC_ICACHE 4'h5
`define CMOD_SC_DCACHE 4'h6
`define CMOD_SC_BOTH 4'h7
`define CMOD_SC_CLEAN 4'ha
`define CMOD_SC_CLINV 4'he
// operation codes
`define CMOD_OP_ENTIRE 3'h0
`define CMOD_OP_ADDR 3'h1
`define CMOD_OP_LOC 3'h2
`define CMOD_OP_WFI 3'h4
`define CMOD_OP_PFB 3'h4
`define CMOD_OP_DRAIN 3'h4
`define CMOD_OP_DMB 3'h5
`define CMOD_OP_DIRTY 3'h6
`define CMOD_OP_BTC_ALL 3'h6
`define CMOD_OP_BTC_ONE 3'h7
// link value offsets
`define CMOD_LINK_WFI 32'h0000_0008
`define CMOD_LINK_RESTART 32'h0000_0004
// operand field positions
`define CMOD_WAY_HI 31
`define CMOD_WAY_LO 30
`define CMOD_SET_LO 5
`define CMOD_SEL_BIT 0
`define CMOD_LINE_LSB 5
`define CMOD_BTC_LSB 3
// cache size parameter: log2 of size field
`define CMOD_SIZE_LOG2 4'h6
// target kinds on the maintenance port
`define CMOD_TGT_ICACHE 3'h1
`define CMOD_TGT_DCACHE 3'h2
`define CMOD_TGT_BOTH 3'h3
`define CMOD_TGT_BTC 3'h4
// action codes
`define CMOD_ACT_INV 2'h1
`define CMOD_ACT_CLEAN 2'h2
`define CMOD_ACT_CLINV 2'h3
// scope codes
`define CMOD_SCP_ALL 2'h0
`define CMOD_SCP_ADDR 2'h1
`define CMOD_SCP_LOC 2'h2
`define CMOD_DIRTY_RST 1'h0
`endif

// >>> hdl/cmod_dirty.v
// dirty status tracker for the data cache
// assumes hit-write pulses from the cache and clean-start pulses
`timescale 1ns/10ps
`include "cmod_defs.vh"
module cmod_dirty (
  input wire i_mclk,
  input wire i_reset,
  input wire i_clean_start,
  input wire i_write_hit,
  output reg o_dirty
);
  // a write hit in the same cycle as a clean start wins, so it is not lost
  always @(posedge i_mclk) begin
    if (i_reset) begin
      o_dirty <= `CMOD_DIRTY_RST;
    end else if (i_write_hit) begin
      o_dirty <= 1'b1;
    end else if (i_clean_start) begin
      o_dirty <= 1'b0;
    end
  end
endmodule

// >>> hdl/cmod_decoder.v
// cache maintenance command decoder and sequencer
// assumes the core presents one command per strobe and holds state
// until o_done; cache, buffers and clocking are outside this block
`timescale 1ns/10ps
`include "cmod_defs.vh"
module cmod_decoder (
  input wire i_mclk,
  input wire i_reset,
  input wire i_cmd_valid,
  input wire i_cmd_read,
  input wire [3:0] i_secondary_code,
  input wire [2:0] i_opcode2,
  input wire [31:0] i_cmd_data,
  input wire [31:0] i_cmd_addr,
  input wire i_privileged,
  input wire i_irq,
  input wire i_debug_req,
  input wire i_maint_done,
  input wire i_write_hit,
  output reg o_busy,
  output reg o_done,
  output reg o_undef_trap,
  output reg o_irq_take,
  output reg [31:0] o_link_value,
  output reg [31:0] o_read_data,
  output reg o_read_valid,
  output reg o_low_power,
  output reg o_maint_req,
  output reg o_maint_abort,
  output reg [2:0] o_maint_target,
  output reg [1:0] o_maint_action,
  output reg [1:0] o_maint_scope,
  output reg o_maint_to_tcm,
  output reg [31:0] o_maint_addr,
  output reg [1:0] o_maint_way,
  output reg [8:0] o_maint_set,
  output reg o_prefetch_flush,
  output reg o_drain_req,
  output reg o_barrier_req
);
  // sequencer states; a new command is only taken in idle
  localparam ST_IDLE = 2'd0;
  localparam ST_MAINT = 2'd1;
  localparam ST_WFI = 2'd2;
  localparam ST_DRAIN = 2'd3;

  // issuing address is kept so the link value can be formed later
  reg [1:0] state;
  reg [31:0] cmd_addr;
  reg clean_start;
  wire dirty;

  // decoded command classes
  reg is_wfi;
  reg is_pfb;
  reg is_drain;
  reg is_dmb;
  reg is_dirty_rd;
  reg is_maint;
  reg user_ok;
  reg [2:0] next_target;
  reg [1:0] next_action;
  reg [1:0] next_scope;
  reg [31:0] next_addr;
  wire [1:0] loc_way;
  wire [8:0] loc_set;
  wire loc_tcm;
  wire is_entire_clean;

  // locator fields; bits between the fields are ignored
  assign loc_way = i_cmd_data[`CMOD_WAY_HI:`CMOD_WAY_LO];
  assign loc_tcm = i_cmd_data[`CMOD_SEL_BIT];

  // set bits above S+2 are should-be-zero; they are dropped so a stray
  // bit cannot pick a set that this cache size does not have
  genvar g_bit;
  generate
    for (g_bit = 0; g_bit < 9; g_bit = g_bit + 1) begin : g_set
      if (g_bit + `CMOD_SET_LO <= `CMOD_SIZE_LOG2 + 2) begin : g_keep
        assign loc_set[g_bit] = i_cmd_data[g_bit + `CMOD_SET_LO];
      end else begin : g_drop
        assign loc_set[g_bit] = 1'b0;
      end
    end
  endgenerate

  // command decode; anything unlisted falls out as a no-operation
  always @* begin
    is_wfi = 1'b0;
    is_pfb = 1'b0;
    is_drain = 1'b0;
    is_dmb = 1'b0;
    is_dirty_rd = 1'b0;
    is_maint = 1'b0;
    next_target = 3'h0;
    next_action = `CMOD_ACT_INV;
    next_scope = `CMOD_SCP_ALL;
    // no context remap: operand goes through, its low bits masked below
    next_addr = i_cmd_data;
    // code c0 holds only the wait command; other ops there are no-ops
    case (i_secondary_code)
      `CMOD_SC_WFI: begin
        is_wfi = (i_opcode2 == `CMOD_OP_WFI);
      end
      `CMOD_SC_ICACHE: begin
        is_pfb = (i_opcode2 == `CMOD_OP_PFB);
        if (i_opcode2 <= `CMOD_OP_LOC) begin
          is_maint = 1'b1;
          next_target = (i_opcode2 == `CMOD_OP_ENTIRE) ?
            `CMOD_TGT_BOTH : `CMOD_TGT_ICACHE;
          next_scope = i_opcode2[1:0];
        end else if (i_opcode2 == `CMOD_OP_BTC_ALL ||
                     i_opcode2 == `CMOD_OP_BTC_ONE) begin
          is_maint = 1'b1;
          next_target = `CMOD_TGT_BTC;
          next_scope = (i_opcode2 == `CMOD_OP_BTC_ONE) ?
            `CMOD_SCP_ADDR : `CMOD_SCP_ALL;
        end
      end
      `CMOD_SC_DCACHE: begin
        if (i_opcode2 <= `CMOD_OP_LOC) begin
          is_maint = 1'b1;
          next_target = `CMOD_TGT_DCACHE;
          next_scope = i_opcode2[1:0];
        end
      end
      `CMOD_SC_BOTH: begin
        if (i_opcode2 == `CMOD_OP_ENTIRE) begin
          is_maint = 1'b1;
          next_target = `CMOD_TGT_BOTH;
        end
      end
      `CMOD_SC_CLEAN: begin
        is_drain = (i_opcode2 == `CMOD_OP_DRAIN);
        is_dmb = (i_opcode2 == `CMOD_OP_DMB);
        is_dirty_rd = (i_opcode2 == `CMOD_OP_DIRTY);
        if (i_opcode2 <= `CMOD_OP_LOC) begin
          is_maint = 1'b1;
          next_target = `CMOD_TGT_DCACHE;
          next_action = `CMOD_ACT_CLEAN;
          next_scope = i_opcode2[1:0];
        end
      end
      `CMOD_SC_CLINV: begin
        if (i_opcode2 <= `CMOD_OP_LOC) begin
          is_maint = 1'b1;
          next_target = `CMOD_TGT_DCACHE;
          next_action = `CMOD_ACT_CLINV;
          next_scope = i_opcode2[1:0];
        end
      end
      default: begin
        is_maint = 1'b0;
      end
    endcase
    // the btc entry keeps bits 3 and up, line ops keep bits 5 and up
    if (next_target == `CMOD_TGT_BTC) begin
      next_addr = {i_cmd_data[31:`CMOD_BTC_LSB], 3'h0};
    end else begin
      next_addr = {i_cmd_data[31:`CMOD_LINE_LSB], 5'h00};
    end
    // user mode may only order memory or refetch; all else traps
    user_ok = is_drain | is_pfb | is_dmb;
  end

  assign is_entire_clean = is_maint && next_scope == `CMOD_SCP_ALL &&
    (next_action == `CMOD_ACT_CLEAN || next_action == `CMOD_ACT_CLINV);

  // clean start pulse clears the dirty flag when a whole clean begins
  always @* begin
    clean_start = 1'b0;
    if (state == ST_IDLE && i_cmd_valid && !i_cmd_read &&
        (i_privileged || user_ok) && is_entire_clean) begin
      clean_start = 1'b1;
    end
  end

  // dirty tracker; hits still count during an interrupted clean
  cmod_dirty u_dirty (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_clean_start(clean_start),
    .i_write_hit(i_write_hit),
    .o_dirty(dirty)
  );

  // sequencer: pulses are cleared each cycle and raised per event
  always @(posedge i_mclk) begin
    if (i_reset) begin
      // every output starts low so the core sees an idle block
      state <= ST_IDLE;
      cmd_addr <= 32'h0000_0000;
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_undef_trap <= 1'b0;
      o_irq_take <= 1'b0;
      o_link_value <= 32'h0000_0000;
      o_read_data <= 32'h0000_0000;
      o_read_valid <= 1'b0;
      o_low_power <= 1'b0;
      o_maint_req <= 1'b0;
      o_maint_abort <= 1'b0;
      o_maint_target <= 3'h0;
      o_maint_action <= 2'h0;
      o_maint_scope <= 2'h0;
      o_maint_to_tcm <= 1'b0;
      o_maint_addr <= 32'h0000_0000;
      o_maint_way <= 2'h0;
      o_maint_set <= 9'h000;
      o_prefetch_flush <= 1'b0;
      o_drain_req <= 1'b0;
      o_barrier_req <= 1'b0;
    end else begin
      o_done <= 1'b0;
      o_undef_trap <= 1'b0;
      o_irq_take <= 1'b0;
      o_read_valid <= 1'b0;
      o_maint_req <= 1'b0;
      o_maint_abort <= 1'b0;
      o_prefetch_flush <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (i_cmd_valid) begin
            cmd_addr <= i_cmd_addr;
            if (i_cmd_read) begin
              if (is_dirty_rd && i_privileged) begin
                // status word carries the flag in bit 0 only
                o_read_data <= {31'h0, dirty};
                o_read_valid <= 1'b1;
                o_done <= 1'b1;
              end else if (is_dirty_rd) begin
                // the status read is not one of the user-mode commands
                o_undef_trap <= 1'b1;
              end else begin
                o_undef_trap <= 1'b1;
              end
            end else if (!i_privileged && !user_ok) begin
              o_undef_trap <= 1'b1;
            end else if (is_wfi) begin
              o_busy <= 1'b1;
              o_low_power <= 1'b1;
              state <= ST_WFI;
            end else if (is_pfb) begin
              // the core refetches everything after this command
              o_prefetch_flush <= 1'b1;
              o_done <= 1'b1;
            end else if (is_drain || is_dmb) begin
              o_drain_req <= is_drain;
              o_barrier_req <= is_dmb;
              o_busy <= 1'b1;
              state <= ST_DRAIN;
            end else if (is_maint) begin
              // invalidates ignore lockdown; misses are the cache's no-op
              o_maint_req <= 1'b1;
              o_maint_target <= next_target;
              o_maint_action <= next_action;
              o_maint_scope <= next_scope;
              o_maint_addr <= next_addr;
              o_maint_way <= loc_way;
              o_maint_set <= loc_set;
              // entire ops never reach tightly coupled memory
              o_maint_to_tcm <= (next_scope == `CMOD_SCP_LOC) ?
                loc_tcm : 1'b0;
              o_busy <= 1'b1;
              state <= ST_MAINT;
            end else begin
              o_done <= 1'b1;
            end
          end
        end
        ST_MAINT: begin
          // only whole cleans are interruptible; a restart redoes them
          if (i_maint_done) begin
            o_busy <= 1'b0;
            o_done <= 1'b1;
            state <= ST_IDLE;
          end else if (i_irq && o_maint_scope == `CMOD_SCP_ALL &&
                       o_maint_action != `CMOD_ACT_INV) begin
            o_maint_abort <= 1'b1;
            o_irq_take <= 1'b1;
            o_link_value <= cmd_addr + `CMOD_LINK_RESTART;
            o_busy <= 1'b0;
            state <= ST_IDLE;
          end
        end
        ST_WFI: begin
          // interrupt masks are not consulted while waiting
          // a debug request ends the wait without taking an interrupt
          if (i_irq || i_debug_req) begin
            o_low_power <= 1'b0;
            o_busy <= 1'b0;
            o_done <= 1'b1;
            o_irq_take <= i_irq;
            o_link_value <= cmd_addr + `CMOD_LINK_WFI;
            state <= ST_IDLE;
          end
        end
        ST_DRAIN: begin
          // drain and barrier both wait for the write buffer to empty
          if (i_maint_done) begin
            o_drain_req <= 1'b0;
            o_barrier_req <= 1'b0;
            o_busy <= 1'b0;
            o_done <= 1'b1;
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// >>> sim/cmod_cache_model.sv
// far-side model: cache and write buffer answering maintenance work
// assumes one request at a time; the bench sets the latency at run time
`timescale 1ns/10ps
module cmod_cache_model (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic [7:0] i_lat,
  input wire logic i_req,
  input wire logic i_level_req,
  input wire logic i_abort,
  output logic o_done
);
  logic [7:0] cnt;
  logic lvl_q;
  // count down from a request; an abort drops the pending answer
  always @(posedge i_mclk) begin
    lvl_q <= i_level_req;
    o_done <= 1'b0;
    if (i_reset || i_abort) begin
      cnt <= 8'h00;
    end else if (cnt == 8'h01) begin
      o_done <= 1'b1;
      cnt <= 8'h00;
    end else if (cnt != 8'h00) begin
      cnt <= cnt - 8'h01;
    end else if (i_req || (i_level_req && !lvl_q)) begin
      cnt <= i_lat;
    end
  end
endmodule

// >>> sim/cmod_decoder_monitor.sv
// assertion checker for the maintenance command decoder
// assumes it is bound onto cmod_decoder and sees only its ports
`timescale 1ns/10ps
module cmod_decoder_monitor (
  input wire i_mclk,
  input wire i_reset,
  input wire i_cmd_valid,
  input wire i_cmd_read,
  input wire [3:0] i_secondary_code,
  input wire [2:0] i_opcode2,
  input wire [31:0] i_cmd_data,
  input wire [31:0] i_cmd_addr,
  input wire i_privileged,
  input wire i_irq,
  input wire i_maint_done,
  input wire i_write_hit,
  input wire o_busy,
  input wire o_done,
  input wire o_undef_trap,
  input wire [31:0] o_link_value,
  input wire [31:0] o_read_data,
  input wire o_read_valid,
  input wire o_low_power,
  input wire o_maint_req,
  input wire o_maint_abort,
  input wire [2:0] o_maint_target,
  input wire [1:0] o_maint_scope,
  input wire o_maint_to_tcm,
  input wire [31:0] o_maint_addr,
  input wire [1:0] o_maint_way,
  input wire [8:0] o_maint_set
);
  logic acc, cstart, clean_q, dirty_m;
  logic [31:0] addr_q, data_q;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  // a command is taken only while idle
  assign acc = i_cmd_valid && !o_busy;
  assign cstart = acc && i_privileged && !i_cmd_read && i_opcode2 == 3'h0 &&
    (i_secondary_code == 4'ha || i_secondary_code == 4'he);
  // shadow of the taken command; a hit wins over a clean start
  always @(posedge i_mclk) begin
    if (acc) begin
      addr_q <= i_cmd_addr;
      data_q <= i_cmd_data;
      clean_q <= cstart;
    end
    if (i_reset) begin
      dirty_m <= 1'b0;
    end else begin
      dirty_m <= i_write_hit || (dirty_m && !cstart);
    end
  end
  maint_done_a:
    assert property (i_maint_done && o_busy && !i_irq |=> o_done)
    else $error("no done after completion");
  trap_user_a:
    assert property (acc && !i_privileged && !i_cmd_read &&
      i_secondary_code == 4'h6 |=> o_undef_trap && !o_maint_req)
    else $error("user invalidate not trapped");
  read_trap_a:
    assert property (acc && i_cmd_read && i_secondary_code != 4'ha &&
      i_secondary_code != 4'hc |=> o_undef_trap && !o_read_valid)
    else $error("bad read not trapped");
  dirty_read_a:
    assert property (acc && i_privileged && i_cmd_read &&
      i_secondary_code == 4'ha && i_opcode2 == 3'h6 |=> o_read_valid &&
      o_read_data == {31'h0000_0000, $past(dirty_m)})
    else $error("dirty status wrong");
  wfi_link_a:
    assert property (o_low_power && i_irq |=> o_done &&
      o_link_value == addr_q + 32'h0000_0008) else $error("wait link wrong");
  clean_abort_a:
    assert property (o_busy && clean_q && i_irq && !i_maint_done |=>
      o_maint_abort && o_link_value == addr_q + 32'h0000_0004)
    else $error("clean abort wrong");
  addr_mask_a:
    assert property (o_maint_req && o_maint_scope == 2'h1 |->
      o_maint_addr == (o_maint_target == 3'h4 ? {data_q[31:3], 3'h0} :
      {data_q[31:5], 5'h00})) else $error("line address wrong");
  // with a size log2 of 6 the set field is bits 8:5, upper set bits zero
  locator_a:
    assert property (o_maint_req && o_maint_scope == 2'h2 |->
      {o_maint_way, o_maint_set, o_maint_to_tcm} ==
      {data_q[31:30], 5'h00, data_q[8:5], data_q[0]})
    else $error("locator wrong");
  user_read_a:
    assert property (acc && !i_privileged && i_cmd_read |=>
      o_undef_trap && !o_read_valid) else $error("user read not trapped");
  entire_tcm_a:
    assert property (o_maint_req && o_maint_scope == 2'h0 |-> !o_maint_to_tcm)
    else $error("entire op hit memory");
endmodule

// >>> sim/testbench.sv
// self-checking bench for the maintenance command decoder
// assumes a cache model on the far side and the checker bound on
`timescale 1ns/10ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module testbench;
  logic i_mclk = 1'b0, i_reset = 1'b1, i_cmd_valid = 1'b0, i_cmd_read = 1'b0;
  logic i_privileged = 1'b1, i_irq = 1'b0, i_debug_req = 1'b0;
  logic i_write_hit = 1'b0, i_maint_done;
  logic [3:0] i_secondary_code = 4'h0;
  logic [2:0] i_opcode2 = 3'h0;
  logic [31:0] i_cmd_data = 32'h0000_0000, i_cmd_addr = 32'h0000_1000;
  logic [7:0] lat = 8'h01;
  logic o_busy, o_done, o_undef_trap, o_irq_take, o_read_valid, o_low_power;
  logic o_maint_req, o_maint_abort, o_maint_to_tcm, o_prefetch_flush;
  logic o_drain_req, o_barrier_req;
  logic [31:0] o_link_value, o_read_data, o_maint_addr;
  logic [2:0] o_maint_target;
  logic [1:0] o_maint_action, o_maint_scope, o_maint_way;
  logic [8:0] o_maint_set;
  logic [15:0] t;
  logic [31:0] ea;
  // code, op, target, action, scope of every cache command
  logic [15:0] tab [0:14] = '{16'h5034, 16'h5115, 16'h5216, 16'h5644,
    16'h5745, 16'h6024, 16'h6125, 16'h6226, 16'h7034, 16'ha028, 16'ha129,
    16'ha22a, 16'he02c, 16'he12d, 16'he22e};
  int bad_count = 0, compares = 0, cycles = 0, i, k;
  cmod_decoder u_cmod_decoder (.*);
  cmod_cache_model u_cmod_cache_model (.i_mclk(i_mclk), .i_reset(i_reset),
    .i_lat(lat), .i_req(o_maint_req),
    .i_level_req(o_drain_req | o_barrier_req),
    .i_abort(o_maint_abort), .o_done(i_maint_done));
  always #5 i_mclk = ~i_mclk;
  // hang guard: the whole run needs well under this many cycles
  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      finish_test;
    end
  end
  task automatic issue(input logic rd, input logic [3:0] s,
      input logic [2:0] o, input logic [31:0] d, input logic p);
    @(negedge i_mclk);
    i_cmd_read = rd;
    i_secondary_code = s;
    i_opcode2 = o;
    i_cmd_data = d;
    i_privileged = p;
    i_cmd_addr = i_cmd_addr + 32'h0000_0004;
    i_cmd_valid = 1'b1;
    @(negedge i_mclk);
    i_cmd_valid = 1'b0;
  endtask
  task idle;
    for (i = 0; i < 80 && o_busy !== 1'b0; i++) @(negedge i_mclk);
    `CHK(o_busy, 1'b0)
  endtask
  task pulse_hit;
    i_write_hit = 1'b1;
    @(negedge i_mclk);
    i_write_hit = 1'b0;
  endtask
  task end_t(input string s);
    $display("test %s finished", s);
  endtask
  task finish_test;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge i_mclk);
    i_reset = 1'b0;
    `CHK({o_busy, o_done, o_maint_req, o_low_power}, 4'h0)
    // prompt and slow answers alternate across the table
    // instruction cache line invalidates are followed by btc flushes in table order
    for (k = 0; k < 15; k++) begin
      t = tab[k];
      lat = k[0] ? 8'h06 : 8'h01;
      issue(1'b0, t[15:12], t[10:8], 32'hc000_2a5f, 1'b1);
      `CHK(o_maint_req, 1'b1)
      `CHK(o_maint_target, t[6:4])
      if (t[6:4] != 3'h4) `CHK(o_maint_action, t[3:2])
      `CHK(o_maint_scope, t[1:0])
      `CHK(o_maint_to_tcm, t[1:0] == 2'h2)
      ea = (t[6:4] == 3'h4) ? 32'hc000_2a58 : 32'hc000_2a40;
      if (t[1:0] == 2'h1) `CHK(o_maint_addr, ea)
      if (t[1:0] == 2'h2) `CHK({o_maint_way, o_maint_set}, 11'h602)
      idle;
    end
    end_t("decode");
    lat = 8'h04;
    issue(1'b0, 4'ha, 3'h4, 32'h0000_0000, 1'b0);
    `CHK({o_undef_trap, o_drain_req}, 2'h1)
    idle;
    issue(1'b0, 4'ha, 3'h5, 32'h0000_0000, 1'b0);
    `CHK({o_undef_trap, o_barrier_req}, 2'h1)
    idle;
    issue(1'b0, 4'h5, 3'h4, 32'h0000_0000, 1'b0);
    `CHK({o_undef_trap, o_prefetch_flush}, 2'h1)
    idle;
    issue(1'b0, 4'h6, 3'h1, 32'h0000_4000, 1'b0);
    `CHK({o_undef_trap, o_maint_req}, 2'h2)
    idle;
    issue(1'b1, 4'ha, 3'h6, 32'h0000_0000, 1'b0);
    `CHK({o_undef_trap, o_read_valid}, 2'h2)
    idle;
    end_t("user mode");
    pulse_hit;
    issue(1'b1, 4'ha, 3'h6, 32'h0000_0000, 1'b1);
    `CHK({o_read_valid, o_read_data}, 33'h1_0000_0001)
    idle;
    issue(1'b0, 4'ha, 3'h0, 32'h0000_0000, 1'b1);
    idle;
    issue(1'b1, 4'ha, 3'h6, 32'h0000_0000, 1'b1);
    `CHK(o_read_data, 32'h0000_0000)
    idle;
    issue(1'b1, 4'h5, 3'h0, 32'h0000_0000, 1'b1);
    `CHK({o_undef_trap, o_read_valid}, 2'h2)
    idle;
    end_t("dirty status");
    // long clean, a write hit inside it, then an interrupt
    lat = 8'h28;
    issue(1'b0, 4'he, 3'h0, 32'h0000_0000, 1'b1);
    pulse_hit;
    i_irq = 1'b1;
    @(negedge i_mclk);
    i_irq = 1'b0;
    `CHK({o_maint_abort, o_irq_take}, 2'h3)
    `CHK(o_link_value, i_cmd_addr + 32'h0000_0004)
    idle;
    issue(1'b1, 4'ha, 3'h6, 32'h0000_0000, 1'b1);
    `CHK(o_read_data, 32'h0000_0001)
    idle;
    end_t("interrupted clean");
    issue(1'b0, 4'h0, 3'h4, 32'h0000_0000, 1'b1);
    `CHK(o_low_power, 1'b1)
    repeat (3) @(negedge i_mclk);
    `CHK({o_low_power, o_done}, 2'h2)
    i_irq = 1'b1;
    @(negedge i_mclk);
    i_irq = 1'b0;
    `CHK({o_done, o_irq_take}, 2'h3)
    `CHK(o_link_value, i_cmd_addr + 32'h0000_0008)
    idle;
    issue(1'b0, 4'h0, 3'h4, 32'h0000_0000, 1'b1);
    i_debug_req = 1'b1;
    @(negedge i_mclk);
    i_debug_req = 1'b0;
    `CHK({o_done, o_irq_take}, 2'h2)
    idle;
    end_t("wait");
    issue(1'b0, 4'h3, 3'h1, 32'h0000_0000, 1'b1);
    `CHK({o_done, o_maint_req, o_undef_trap}, 3'h4)
    idle;
    end_t("unlisted");
    finish_test;
  end
endmodule
bind cmod_decoder cmod_decoder_monitor u_cmod_decoder_monitor (.*);
